// >>> common/pss_pkg.sv
// Purpose: Shared constants for the pipelined memory input and data stage
// Assumes: One device clock at 125 MHz, 18-bit word split into two lanes
// Notes:   All widths and latencies used by the stage live here

package pss_pkg;

    // Word and lane geometry
    localparam int LANE_W   = 9;                // Bits per byte lane
    localparam int LANES    = 2;                // Number of byte lanes
    localparam int WORD_W   = LANE_W * LANES;   // Full word width
    localparam int ADDR_W   = 19;               // Word address width
    localparam int BURST_W  = 2;                // Burst counter width
    localparam int DEPTH    = 1 << ADDR_W;      // Words in the array

    // Data bus latency, in device clock cycles, from sampled control
    localparam int DATA_LAT = 2;

    // Clock figures
    localparam int CLK_MHZ  = 125;
    localparam int CLK_NS   = 1000 / CLK_MHZ;

    // Constant values met by narrow signals
    localparam logic [BURST_W-1:0] BURST_ZERO = 2'h0;
    localparam logic [BURST_W-1:0] BURST_ONE  = 2'h1;
    localparam logic [LANES-1:0]   LANES_NONE = 2'h0;
    localparam logic [WORD_W-1:0]  WORD_ZERO  = 18'h0;
    localparam logic [ADDR_W-1:0]  ADDR_ZERO  = 19'h0;

    // Burst sequencer states, one-hot
    typedef enum logic [1:0] {
        PSS_IDLE  = 2'h1,
        PSS_BURST = 2'h2
    } pss_state_t;

endpackage : pss_pkg

// >>> rtl/pss_input_stage.sv
// Purpose: Input registers, burst counter and late-write data path of a
//          pipelined static memory with two nine-bit byte lanes
// Assumes: Host logic drives all inputs from the same core_clk edge
// Notes:   Data bus activity lags its control cycle by DATA_LAT edges;
//          a cycle with clock_enable_n high is invisible to all state

`timescale 1ns/10ps

// Behaviour
// - Write data and read data are clocked registers
// - Address loads on load-select low, enabled, selected
// - Burst counter seeded from two low address bits
// - One active-low write enable per nine-bit lane
// - Lane enables ignored when read selected
// - Selected lanes stored two cycles after sampling
// - Clock enable high ignores inputs, outputs hold
// - Clock enable high leaves all state untouched
// - Direction fixed at load; data two cycles later
// - Load-select high advances burst, ignores address
// - Deselect floats data bus two cycles later
// - Order input high interleaved, low linear
module pss_input_stage (
    // Clock and reset
    input  wire logic                          core_clk,
    input  wire logic                          rst_n,
    // Control pins
    input  wire logic                          clock_enable_n,
    input  wire logic                          advance_or_load_select,
    input  wire logic                          read_write_select,
    input  wire logic                          chip_select_first_n,
    input  wire logic                          chip_select_high,
    input  wire logic                          chip_select_third_n,
    input  wire logic                          burst_order_select,
    // Address pins
    input  wire logic [pss_pkg::ADDR_W-1:0]    address,
    // Lane write enables
    input  wire logic                          first_lane_write_enable_n,
    input  wire logic                          second_lane_write_enable_n,
    // Data pins, split into input, output and enable
    input  wire logic [pss_pkg::LANE_W-1:0]    first_lane_data_in,
    input  wire logic [pss_pkg::LANE_W-1:0]    second_lane_data_in,
    output logic      [pss_pkg::LANE_W-1:0]    first_lane_data_out,
    output logic      [pss_pkg::LANE_W-1:0]    second_lane_data_out,
    output logic                               data_oe_n
);
    import pss_pkg::*;

    // Lane views of the pins
    logic [LANES-1:0]        lane_write_enable_n;           // Per-lane enable, active low
    logic [WORD_W-1:0]       word_in;                       // Write data as one word
    logic [LANE_W-1:0]       mem_lane [LANES][DEPTH];       // Storage, one array per lane
    logic [WORD_W-1:0]       rd_word_q;                     // Read data output register
    logic                    oe_n_q;                        // Bus float control

    // Burst sequencer state
    // Only two states: a burst is live or it is not
    pss_state_t              state_q;
    pss_state_t              state_d;
    logic [ADDR_W-1:0]       base_q;                        // Loaded address
    logic [BURST_W-1:0]      cnt_q;                         // Steps taken in burst
    logic                    wr_q;                          // Direction of burst

    // Pipeline stages between control and data
    // They carry an op's control to its data edge and freeze on a stall,
    // so a suspended host never loses a write that is still in flight
    logic                    s1_valid_q, s2_valid_q;
    logic                    s1_write_q, s2_write_q;
    logic [ADDR_W-1:0]       s1_addr_q, s2_addr_q;
    logic [LANES-1:0]        s1_lanes_q, s2_lanes_q;

    // Decode of the current cycle
    // An advance counts only inside a burst, so a stray advance after
    // a deselect cannot revive the old address
    wire                     step      = ~clock_enable_n;
    wire                     selected  = ~chip_select_first_n & chip_select_high
                                         & ~chip_select_third_n;
    wire                     load      = step & ~advance_or_load_select & selected;
    wire                     deselect  = step & ~advance_or_load_select & ~selected;
    wire                     advance   = step & advance_or_load_select
                                         & (state_q == PSS_BURST);
    wire [BURST_W-1:0]       cnt_nx    = cnt_q + BURST_ONE;
    wire [BURST_W-1:0]       seed      = base_q[BURST_W-1:0];
    // Interleaved order when the order input is high, else linear
    wire [BURST_W-1:0]       low_nx    = burst_order_select ? (seed ^ cnt_nx)
                                                            : (seed + cnt_nx);
    wire [ADDR_W-1:0]        burst_addr = {base_q[ADDR_W-1:BURST_W], low_nx};
    wire                     op_valid  = load | advance;
    // Direction comes from the pin only on a load
    wire                     op_write  = load ? ~read_write_select : wr_q;
    wire [ADDR_W-1:0]        op_addr   = load ? address : burst_addr;
    // Lane enables count only on writes; reads disregard them
    wire [LANES-1:0]         op_lanes  = (op_valid & op_write) ? ~lane_write_enable_n
                                                               : LANES_NONE;

    assign lane_write_enable_n = {second_lane_write_enable_n,
                                  first_lane_write_enable_n};
    assign word_in             = {second_lane_data_in, first_lane_data_in};
    assign first_lane_data_out  = rd_word_q[LANE_W-1:0];
    assign second_lane_data_out = rd_word_q[WORD_W-1:LANE_W];
    assign data_oe_n           = oe_n_q;

    // Sequencer next state; deselect stops a burst in progress
    always_comb begin
        state_d = state_q;
        if (load) begin
            state_d = PSS_BURST;
        end else if (deselect) begin
            state_d = PSS_IDLE;
        end
    end

    // Address, direction and burst counter
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            state_q <= PSS_IDLE;
            base_q  <= ADDR_ZERO;
            cnt_q   <= BURST_ZERO;
            wr_q    <= 1'b0;
        end else if (step) begin
            state_q <= state_d;
            if (load) begin
                base_q <= address;
                cnt_q  <= BURST_ZERO;
                wr_q   <= ~read_write_select;
            end else if (advance) begin
                cnt_q  <= cnt_nx;
            end
        end
    end

    // Two control stages make up the data latency
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            s1_valid_q <= 1'b0;
            s2_valid_q <= 1'b0;
            s1_write_q <= 1'b0;
            s2_write_q <= 1'b0;
            s1_addr_q  <= ADDR_ZERO;
            s2_addr_q  <= ADDR_ZERO;
            s1_lanes_q <= LANES_NONE;
            s2_lanes_q <= LANES_NONE;
        end else if (step) begin
            s1_valid_q <= op_valid;
            s1_write_q <= op_write;
            s1_addr_q  <= op_addr;
            s1_lanes_q <= op_lanes;
            s2_valid_q <= s1_valid_q;
            s2_write_q <= s1_write_q;
            s2_addr_q  <= s1_addr_q;
            s2_lanes_q <= s1_lanes_q;
        end
    end

    // Output register; a stall freezes the bus as if no edge came
    // Read data is taken from the array at the data edge itself, so a
    // write at an earlier data edge is always seen by a later read
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            rd_word_q <= WORD_ZERO;
            oe_n_q    <= 1'b1;
        end else if (step) begin
            // Writes and deselects both float the bus
            oe_n_q <= ~(s2_valid_q & ~s2_write_q);
            if (s2_valid_q & ~s2_write_q) begin
                for (int l = 0; l < LANES; l++) begin
                    rd_word_q[l*LANE_W +: LANE_W] <= mem_lane[l][s2_addr_q];
                end
            end
        end
    end

    // Late write, one lane per generate entry; storage is not reset
    for (genvar g = 0; g < LANES; g++) begin : g_lane
        always_ff @(posedge core_clk) begin
            if (rst_n && step && s2_valid_q && s2_write_q && s2_lanes_q[g]) begin
                mem_lane[g][s2_addr_q] <= word_in[g*LANE_W +: LANE_W];
            end
        end
    end

    // Checks on the data path and burst logic
    // Burst steps are checked as an offset from the previous word and
    // from the seed, not with the sequencer's own arithmetic
    a_stall_holds_bus: assert property (@(posedge core_clk) disable iff (!rst_n)
        clock_enable_n |=> $stable(data_oe_n) && $stable(rd_word_q))
        else $error("Bus outputs moved during a clock enable stall");
    a_stall_holds_state: assert property (@(posedge core_clk) disable iff (!rst_n)
        clock_enable_n |=> $stable(cnt_q) && $stable(base_q) && $stable(s1_valid_q))
        else $error("Internal state moved during a clock enable stall");
    a_load_takes_addr: assert property (@(posedge core_clk) disable iff (!rst_n)
        load |=> base_q == $past(address) && cnt_q == BURST_ZERO)
        else $error("Address register did not load on a selected load cycle");
    a_no_load_hold: assert property (@(posedge core_clk) disable iff (!rst_n)
        !load |=> $stable(base_q))
        else $error("Address register changed without a load cycle");
    a_read_ignores_lanes: assert property (@(posedge core_clk) disable iff (!rst_n)
        (load && read_write_select) |=> s1_lanes_q == LANES_NONE)
        else $error("Lane enables honoured on a read");
    a_write_lat_two: assert property (@(posedge core_clk) disable iff (!rst_n)
        (load && !read_write_select && !clock_enable_n) ##1 !clock_enable_n
        |=> s2_valid_q && s2_write_q && s2_addr_q == $past(address, 2))
        else $error("Write did not reach the array stage two cycles later");
    a_read_drives_bus: assert property (@(posedge core_clk) disable iff (!rst_n)
        (load && read_write_select) ##1 !clock_enable_n ##1 !clock_enable_n
        |=> !data_oe_n)
        else $error("Read data not driven two cycles after the load");
    a_deselect_floats: assert property (@(posedge core_clk) disable iff (!rst_n)
        deselect ##1 !clock_enable_n ##1 (!clock_enable_n && !advance_or_load_select)
        |=> data_oe_n)
        else $error("Bus not floated two cycles after deselect");
    a_burst_order: assert property (@(posedge core_clk) disable iff (!rst_n)
        advance && !burst_order_select |=> s1_addr_q[BURST_W-1:0]
            == BURST_W'($past(s1_addr_q[BURST_W-1:0]) + BURST_ONE)
            && s1_addr_q[ADDR_W-1:BURST_W] == $past(s1_addr_q[ADDR_W-1:BURST_W]))
        else $error("Linear burst address step is wrong");
    a_burst_xor_step: assert property (@(posedge core_clk) disable iff (!rst_n)
        advance && burst_order_select |=> (s1_addr_q[BURST_W-1:0] ^ base_q[BURST_W-1:0])
            == BURST_W'($past(s1_addr_q[BURST_W-1:0] ^ base_q[BURST_W-1:0]) + BURST_ONE))
        else $error("Interleaved burst address step is wrong");

endmodule : pss_input_stage

// >>> tb/pss_host_model.sv
// Purpose: Host controller model driving the memory stage pins
// Assumes: drive is called just after a rising core_clk edge
// Notes:   Write data trails its control by two active edges
`timescale 1ns/10ps
module pss_host_model (
    // Clock
    input  wire logic                        core_clk,
    // Control, address and lane enables
    output logic                             clock_enable_n,
    output logic                             advance_or_load_select,
    output logic                             read_write_select,
    output logic                             chip_select_first_n,
    output logic                             chip_select_high,
    output logic                             chip_select_third_n,
    output logic                             burst_order_select,
    output logic                             first_lane_write_enable_n,
    output logic                             second_lane_write_enable_n,
    output logic      [pss_pkg::ADDR_W-1:0]  address,
    // Write data toward the device
    output logic      [pss_pkg::LANE_W-1:0]  first_lane_data_in,
    output logic      [pss_pkg::LANE_W-1:0]  second_lane_data_in
);
    import pss_pkg::*;
    logic              wr_burst = 1'b0;         // Current burst carries writes
    logic [WORD_W:0]   next_w   = '0;           // Write flag and data of this cycle
    logic [WORD_W:0]   stage_a  = '0;           // One active edge old
    logic [WORD_W:0]   stage_b  = '0;           // Two active edges old
    logic [WORD_W-1:0] junk_q   = 18'h15a5a;    // Filler so a released bus never looks valid

    // Data pipeline only moves on active edges, like the device
    always @(posedge core_clk) begin
        junk_q <= junk_q + 18'h0b5a3;
        if (!clock_enable_n) begin
            stage_a <= next_w;
            stage_b <= stage_a;
        end
    end
    assign {second_lane_data_in, first_lane_data_in} = stage_b[WORD_W] ? stage_b[WORD_W-1:0]
                                                                        : junk_q;

    // One bus cycle: ctl = {stall, advance, read, order}
    task automatic drive(input logic [3:0] ctl, input logic [2:0] sel,
                         input logic [ADDR_W-1:0] addr, input logic [1:0] we,
                         input logic [WORD_W-1:0] wd);
        if (!ctl[3] && !ctl[2]) wr_burst = (sel == 3'h2) && !ctl[1];
        {clock_enable_n, advance_or_load_select, read_write_select, burst_order_select} = ctl;
        {chip_select_first_n, chip_select_high, chip_select_third_n} = sel;
        {second_lane_write_enable_n, first_lane_write_enable_n} = we;
        address = addr;
        next_w = {wr_burst, wd};
    endtask : drive
endmodule : pss_host_model

// >>> tb/testbench.sv
// Purpose: Self-checking bench for the pipelined memory input stage
// Assumes: Rows hold pin values and the result of the row two active cycles back
// Notes:   Stalled rows expect the previous outputs to hold
`timescale 1ns/10ps
module testbench;
    import pss_pkg::*;
    typedef struct { logic [3:0] ctl; logic [2:0] sel; logic [ADDR_W-1:0] addr; logic [1:0] we;
        logic [WORD_W-1:0] wd; logic eoe; logic [WORD_W-1:0] ed; } pss_row_t;
    logic core_clk = 1'b0, rst_n = 1'b0, data_oe_n;
    logic clock_enable_n, advance_or_load_select, read_write_select, chip_select_first_n;
    logic chip_select_high, chip_select_third_n, burst_order_select;
    logic first_lane_write_enable_n, second_lane_write_enable_n;
    logic [ADDR_W-1:0] address;
    logic [LANE_W-1:0] first_lane_data_in, second_lane_data_in;
    logic [LANE_W-1:0] first_lane_data_out, second_lane_data_out;
    int   err_count = 0, check_count = 0;
    pss_row_t rows [25];

    always #(CLK_NS / 2) core_clk = ~core_clk;

    pss_host_model pss_host_model_i (.core_clk, .clock_enable_n, .advance_or_load_select,
        .read_write_select, .chip_select_first_n, .chip_select_high, .chip_select_third_n,
        .burst_order_select, .address, .first_lane_write_enable_n, .second_lane_write_enable_n,
        .first_lane_data_in, .second_lane_data_in);
    pss_input_stage pss_input_stage_i (.core_clk, .rst_n, .clock_enable_n, .advance_or_load_select,
        .read_write_select, .chip_select_first_n, .chip_select_high, .chip_select_third_n,
        .burst_order_select, .address, .first_lane_write_enable_n, .second_lane_write_enable_n,
        .first_lane_data_in, .second_lane_data_in, .first_lane_data_out,
        .second_lane_data_out, .data_oe_n);

    // Compare one value, four-state exact
    task automatic check_val(input string what, input logic [WORD_W-1:0] exp, got);
        check_count++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask : check_val

    // Verdict and end of run
    task automatic summarize;
        $display("checks %0d errors %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : summarize

    // Watchdog well beyond the few dozen cycles the run needs
    initial begin
        #(CLK_NS * 2000);
        err_count++;
        summarize();
    end

    initial begin
        rows = '{'{4'h0,3'h2,19'h20,2'h0,18'h00f0f,1'h1,18'h0},
            '{4'h0,3'h2,19'h10,2'h0,18'h12345,1'h1,18'h0}, '{4'h0,3'h2,19'h11,2'h0,18'h0aaaa,1'h1,18'h0},
            '{4'h0,3'h2,19'h11,2'h2,18'h3ffff,1'h1,18'h0}, '{4'h8,3'h2,19'h10,2'h0,18'h0,1'h1,18'h0},
            '{4'h2,3'h2,19'h10,2'h0,18'h0,1'h1,18'h0}, '{4'h2,3'h2,19'h11,2'h0,18'h0,1'h1,18'h0},
            '{4'h0,3'h0,19'h11,2'h0,18'h0,1'h0,18'h12345}, '{4'h4,3'h2,19'h10,2'h0,18'h0,1'h0,18'h0abff},
            '{4'h8,3'h0,19'h0,2'h0,18'h0,1'h0,18'h0abff}, '{4'h0,3'h2,19'h22,2'h0,18'h11111,1'h1,18'h0},
            '{4'h4,3'h2,19'h0,2'h0,18'h22222,1'h1,18'h0}, '{4'h4,3'h2,19'h0,2'h3,18'h33333,1'h1,18'h0},
            '{4'h4,3'h2,19'h0,2'h0,18'h04444,1'h1,18'h0}, '{4'h3,3'h2,19'h21,2'h0,18'h0,1'h1,18'h0},
            '{4'h5,3'h2,19'h0,2'h0,18'h0,1'h1,18'h0}, '{4'h5,3'h2,19'h7ffff,2'h0,18'h0,1'h0,18'h04444},
            '{4'h5,3'h2,19'h0,2'h0,18'h0,1'h0,18'h00f0f}, '{4'h5,3'h2,19'h0,2'h0,18'h0,1'h0,18'h22222},
            '{4'h1,3'h6,19'h0,2'h0,18'h0,1'h0,18'h11111}, '{4'h5,3'h2,19'h0,2'h0,18'h0,1'h0,18'h04444},
            '{4'h2,3'h2,19'h10,2'h0,18'h0,1'h1,18'h0}, '{4'h6,3'h2,19'h0,2'h0,18'h0,1'h1,18'h0},
            '{4'h0,3'h3,19'h0,2'h0,18'h0,1'h0,18'h12345},
            '{4'h4,3'h2,19'h0,2'h0,18'h0,1'h0,18'h0abff}};
        pss_host_model_i.drive(4'h4, 3'h2, ADDR_ZERO, 2'h3, WORD_ZERO);
        repeat (12) @(posedge core_clk);
        #1 rst_n = 1'b1;
        @(posedge core_clk);
        #1;
        // Table of ordinary and burst cycles, stalls included
        foreach (rows[i]) begin
            pss_host_model_i.drive(rows[i].ctl, rows[i].sel, rows[i].addr, rows[i].we, rows[i].wd);
            @(posedge core_clk);
            #1;
            check_val("bus float", {17'h0, rows[i].eoe}, {17'h0, data_oe_n});
            if (!rows[i].eoe) check_val("read word", rows[i].ed,
                {second_lane_data_out, first_lane_data_out});
        end
        // Reset with a read in flight clears the pipeline
        pss_host_model_i.drive(4'h2, 3'h2, 19'h10, 2'h0, WORD_ZERO);
        @(posedge core_clk);
        #1 rst_n = 1'b0;
        pss_host_model_i.drive(4'h4, 3'h2, ADDR_ZERO, 2'h3, WORD_ZERO);
        @(posedge core_clk);
        #1;
        check_val("reset clears data", WORD_ZERO, {second_lane_data_out, first_lane_data_out});
        @(posedge core_clk);
        #1 rst_n = 1'b1;
        repeat (3) @(posedge core_clk);
        #1;
        check_val("reset float", 18'h1, {17'h0, data_oe_n});
        check_val("reset data", WORD_ZERO, {second_lane_data_out, first_lane_data_out});
        summarize();
    end
endmodule : testbench
